// ===== ctr_defs.vh
// shared constants for the counter/timer channel
`ifndef CTR_DEFS_VH
`define CTR_DEFS_VH
// register offsets (word index on the plain register port)
`define ADDR_CTRL     4'h0
`define ADDR_DIVIDER  4'h1
`define ADDR_ACTIVE   4'h2
`define ADDR_WINDOW   4'h3
`define ADDR_COUNT    4'h4
`define ADDR_STATUS   4'h5
// control field positions
`define CTRL_EN       0
`define CTRL_MODE_LO  1
`define CTRL_MODE_HI  3
`define CTRL_SRC      4
`define CTRL_GATE_LO  5
`define CTRL_GATE_HI  7
`define CTRL_POL      8
// modes
`define MODE_COUNT    3'h0
`define MODE_FREQ_WIN 3'h1
`define MODE_RATE     3'h2
`define MODE_ONESHOT  3'h3
`define MODE_REPEAT   3'h4
// gate types
`define GATE_NONE     3'h0
`define GATE_LOW      3'h1
`define GATE_HIGH     3'h2
`define GATE_FALL     3'h3
`define GATE_RISE     3'h4
// reset values
`define RST_DIVIDER   16'h0002
`define RST_ACTIVE    16'h0001
`define RST_WINDOW    16'h0001
// timing
`define MCLK_HZ       20000000
`define TBASE_HZ      12000000
`define WIN_UNIT_US   1000
`define WIN_UNIT_CYC  ((`MCLK_HZ / 1000000) * `WIN_UNIT_US)
`endif

// ===== edge_sync.v
// two-stage synchroniser with edge detection on the settled sample
`timescale 1ns/1ps
module edge_sync (
    // clock and reset
    input  wire mclk_in,
    input  wire rst_n_in,
    // raw input and conditioned outputs
    input  wire raw_in,
    output wire level_out,
    output wire rise_out,
    output wire fall_out
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // first stage feeds only the second stage
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges compare settled stages only
    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;
    assign fall_out  = ~sync_q & prev_q;
endmodule

// ===== tbase_gen.v
// fractional divider making 12 mhz ticks from the module clock
`timescale 1ns/1ps
module tbase_gen #(
    parameter integer CLK_HZ  = 20000000,
    parameter integer TICK_HZ = 12000000
) (
    // clock and reset
    input  wire mclk_in,
    input  wire rst_n_in,
    // tick output
    output reg  tick_out
);
    reg [31:0] acc_q;
    wire [32:0] sum = {1'b0, acc_q} + TICK_HZ;

    // phase accumulator, one tick per wrap
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q    <= 32'h00000000;
            tick_out <= 1'b0;
        end else if (sum >= CLK_HZ) begin
            acc_q    <= sum[31:0] - CLK_HZ;
            tick_out <= 1'b1;
        end else begin
            acc_q    <= sum[31:0];
            tick_out <= 1'b0;
        end
    end
endmodule

// ===== ctr_timer.v
// one 16-bit counter/timer channel with pulse and measurement modes
// Summary of operation
// - windowed mode counts events over millisecond window
// - gated mode counts only during active gate
// - rate mode outputs pulses continuously while enabled
// - disabling stops rate output at once
// - output period equals clock period times divider
// - rate uses either source, high-level gate
// - one-shot gives one pulse on the first trigger edge
// - one-shot stops and ignores later edges
// - inactive part comes first after trigger
// - repetitive one-shot pulses on every trigger
// - triggers during a pulse are dropped
// - polarity picks active half, duty sets width
// - internal clock from 12 MHz time base
// - external divider 2 to 65536, rising edge
// - high level gate enables, low suspends
`timescale 1ns/1ps
`include "ctr_defs.vh"
module ctr_timer #(
    parameter integer WIN_UNIT_CYC = `WIN_UNIT_CYC
) (
    // clock and reset
    input  wire        mclk_in,
    input  wire        rst_n_in,
    // register port
    input  wire [3:0]  addr_in,
    input  wire [15:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [15:0] rdata_out,
    // external pins
    input  wire        ext_clk_in,
    input  wire        gate_in,
    output reg         pulse_out
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;

    reg        rst_a_q;
    reg        rst_b_q;
    wire       rst_n = rst_b_q;
    reg [8:0]  ctrl_q;
    reg [15:0] divider_q;
    reg [15:0] active_q;
    reg [15:0] window_q;
    reg [15:0] count_q;
    reg [15:0] remain_q;
    reg [15:0] win_ms_q;
    reg [15:0] win_cyc_q;
    reg [1:0]  state_q;
    reg        win_done_q;
    reg        en_prev_q;

    wire       ext_lvl;
    wire       ext_rise;
    wire       gate_lvl;
    wire       gate_rise;
    wire       gate_fall;
    wire       tb_tick;

    wire       enable  = ctrl_q[`CTRL_EN];
    wire [2:0] mode    = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire [2:0] gtype   = ctrl_q[`CTRL_GATE_HI:`CTRL_GATE_LO];
    wire       use_ext = ctrl_q[`CTRL_SRC];
    wire       pol_hi  = ctrl_q[`CTRL_POL];
    wire       start   = enable & ~en_prev_q;

    // reset release through two flops
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end

    // pin conditioning
    edge_sync u_ext_sync (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n),
        .raw_in    (ext_clk_in),
        .level_out (ext_lvl),
        .rise_out  (ext_rise),
        .fall_out  ()
    );
    edge_sync u_gate_sync (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n),
        .raw_in    (gate_in),
        .level_out (gate_lvl),
        .rise_out  (gate_rise),
        .fall_out  (gate_fall)
    );
    tbase_gen #(
        .CLK_HZ  (`MCLK_HZ),
        .TICK_HZ (`TBASE_HZ)
    ) u_tbase (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n),
        .tick_out (tb_tick)
    );

    // selected clock edge: ext rising edge or internal tick
    wire clk_tick = use_ext ? ext_rise : tb_tick;

    // level gate qualification
    reg gate_ok;
    always @* begin
        case (gtype)
            `GATE_LOW:  gate_ok = ~gate_lvl;
            `GATE_HIGH: gate_ok = gate_lvl;
            default:    gate_ok = 1'b1;
        endcase
    end

    // trigger edge for one-shot modes
    wire trig = (gtype == `GATE_FALL) ? gate_fall :
                (gtype == `GATE_RISE) ? gate_rise : 1'b0;

    wire is_shot = (mode == `MODE_ONESHOT) | (mode == `MODE_REPEAT);
    wire run_ok  = enable & gate_ok;

    // period reload; divider 0 stands for 65536
    wire [15:0] reload = divider_q - 16'h0001;
    wire        at_end = (remain_q == 16'h0000);
    wire        act    = (remain_q < active_q);

    // register writes and pulse engine
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= 9'h000;
            divider_q <= `RST_DIVIDER;
            active_q  <= `RST_ACTIVE;
            window_q  <= `RST_WINDOW;
            en_prev_q <= 1'b0;
            remain_q  <= 16'h0000;
            state_q   <= ST_IDLE;
            pulse_out <= 1'b0;
        end else begin
            en_prev_q <= enable;
            if (wr_in) begin
                case (addr_in)
                    `ADDR_CTRL:    ctrl_q    <= wdata_in[8:0];
                    `ADDR_DIVIDER: divider_q <= wdata_in;
                    `ADDR_ACTIVE:  active_q  <= wdata_in;
                    `ADDR_WINDOW:  window_q  <= wdata_in;
                    default:       ;
                endcase
            end
            case (state_q)
                ST_IDLE: begin
                    pulse_out <= ~pol_hi;
                    remain_q  <= reload;
                    if (start && mode == `MODE_RATE) begin
                        state_q <= ST_RUN;
                    end else if (enable && is_shot && trig) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!enable) begin
                        state_q   <= ST_IDLE;
                        pulse_out <= ~pol_hi;
                    end else if (mode == `MODE_RATE && !run_ok) begin
                        pulse_out <= ~pol_hi;
                        remain_q  <= reload;
                    end else begin
                        // inactive part first, then active tail
                        pulse_out <= act ? pol_hi : ~pol_hi;
                        if (clk_tick) begin
                            if (at_end) begin
                                remain_q <= reload;
                                if (mode == `MODE_ONESHOT) begin
                                    state_q <= ST_DONE;
                                end else if (mode == `MODE_REPEAT) begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                remain_q <= remain_q - 16'h0001;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    pulse_out <= ~pol_hi;
                    if (!enable) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (wr_in && addr_in == `ADDR_CTRL) begin
                state_q <= ST_IDLE;
            end
        end
    end

    // event counter for counting and measurement modes
    wire win_mode = (mode == `MODE_FREQ_WIN);
    wire cnt_mode = (mode == `MODE_COUNT) | win_mode;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            count_q    <= 16'h0000;
            win_ms_q   <= 16'h0000;
            win_cyc_q  <= 16'h0000;
            win_done_q <= 1'b0;
        end else if (start) begin
            count_q    <= 16'h0000;
            win_ms_q   <= 16'h0000;
            win_cyc_q  <= 16'h0000;
            win_done_q <= 1'b0;
        end else if (enable && cnt_mode) begin
            if (win_mode && !win_done_q) begin
                // millisecond timer closes the window
                if (win_cyc_q == WIN_UNIT_CYC[15:0] - 16'h0001) begin
                    win_cyc_q <= 16'h0000;
                    win_ms_q  <= win_ms_q + 16'h0001;
                    if (win_ms_q + 16'h0001 >= window_q) begin
                        win_done_q <= 1'b1;
                    end
                end else begin
                    win_cyc_q <= win_cyc_q + 16'h0001;
                end
            end
            // gated count only while gate active; relies on software polarity
            if (ext_rise && gate_ok && !(win_mode && win_done_q)) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // read mux, data one cycle after strobe
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `ADDR_CTRL:    rdata_out <= {7'h00, ctrl_q};
                `ADDR_DIVIDER: rdata_out <= divider_q;
                `ADDR_ACTIVE:  rdata_out <= active_q;
                `ADDR_WINDOW:  rdata_out <= window_q;
                `ADDR_COUNT:   rdata_out <= count_q;
                `ADDR_STATUS:  rdata_out <= {11'h000, ext_lvl, gate_lvl,
                                            win_done_q, state_q};
                default:       rdata_out <= 16'h0000;
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule

// ===== ctr_timer_chk.sv
// port-level assertions for the counter/timer channel
`timescale 1ns/1ps
`include "ctr_defs.vh"
module ctr_timer_chk #(
    parameter integer WIN_UNIT_CYC = 20
) (
    // clock, reset and register port
    input wire        mclk_in,
    input wire        rst_n_in,
    input wire [3:0]  addr_in,
    input wire [15:0] wdata_in,
    input wire        wr_in,
    input wire        rd_in,
    input wire [15:0] rdata_out,
    // pins
    input wire        ext_clk_in,
    input wire        gate_in,
    input wire        pulse_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    reg  [15:0] ctrl_q, div_q, act_q, win_q;
    reg  [1:0]  shots_q;
    reg         pulse_q;
    wire [2:0]  mode = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire        idle = ~ctrl_q[`CTRL_POL];
    wire        wr_c = wr_in && addr_in == `ADDR_CTRL;
    // shadow registers; pulse tally restarts on every control write
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q  <= 16'h0000;
            div_q   <= `RST_DIVIDER;
            act_q   <= `RST_ACTIVE;
            win_q   <= `RST_WINDOW;
            shots_q <= 2'h0;
            pulse_q <= 1'h0;
        end else begin
            pulse_q <= pulse_out;
            if (wr_c) ctrl_q <= wdata_in;
            if (wr_in && addr_in == `ADDR_DIVIDER) div_q <= wdata_in;
            if (wr_in && addr_in == `ADDR_ACTIVE) act_q <= wdata_in;
            if (wr_in && addr_in == `ADDR_WINDOW) win_q <= wdata_in;
            if (wr_c) shots_q <= 2'h0;
            else if (pulse_out != idle && pulse_q == idle && shots_q != 2'h3)
                shots_q <= shots_q + 2'h1;
        end
    end
    a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (rd_in && addr_in > 4'h5 |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_ctrl_back: assert property (rd_in && addr_in == `ADDR_CTRL |=> rdata_out[8:0] == ctrl_q[8:0])
        else $error("control readback wrong");
    a_div_back: assert property (rd_in && addr_in == `ADDR_DIVIDER |=> rdata_out == div_q)
        else $error("divider readback wrong");
    a_act_back: assert property (rd_in && addr_in == `ADDR_ACTIVE |=> rdata_out == act_q)
        else $error("active count readback wrong");
    a_win_back: assert property (rd_in && addr_in == `ADDR_WINDOW |=> rdata_out == win_q)
        else $error("window readback wrong");
    a_idle_level: assert property ((!ctrl_q[0] && $stable(ctrl_q))[*6] |-> pulse_out == idle)
        else $error("output not idle while disabled");
    a_gate_halts: assert property ((mode == `MODE_RATE && ctrl_q[0] && !gate_in
        && ctrl_q[7:5] == `GATE_HIGH)[*6] |-> pulse_out == idle)
        else $error("rate output active with gate low");
    a_one_shot: assert property (ctrl_q[0] && mode == `MODE_ONESHOT |-> shots_q < 2'h2)
        else $error("one-shot gave a second pulse");
endmodule
bind ctr_timer ctr_timer_chk #(.WIN_UNIT_CYC(WIN_UNIT_CYC)) u_chk (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_clk_in(ext_clk_in),
    .gate_in(gate_in), .pulse_out(pulse_out));

// ===== ext_wiring.sv
// far-side model: external clock source giving bursts of edges
`timescale 1ns/1ps
module ext_wiring (
    // module clock and burst request
    input  wire       mclk_in,
    input  wire       go_in,
    input  wire [7:0] edges_in,
    // clock pin and status
    output reg        ext_clk_out = 1'h0,
    output wire       busy_out
);
    localparam integer HALF = 3;
    reg [8:0] left_q = 9'h000;
    reg [7:0] div_q  = 8'h00;
    assign busy_out = (left_q != 9'h000);
    // clock stands low between bursts; slow enough for the pin synchroniser
    always @(posedge mclk_in) begin
        if (go_in) begin
            left_q <= {edges_in, 1'h0};
            div_q  <= 8'h00;
        end else if (busy_out) begin
            div_q <= (div_q == HALF - 1) ? 8'h00 : div_q + 8'h01;
            if (div_q == HALF - 1) begin
                ext_clk_out <= ~ext_clk_out;
                left_q      <= left_q - 9'h001;
            end
        end
    end
endmodule

// ===== tb_ctr_timer.sv
// testbench for the counter/timer channel
`timescale 1ns/1ps
`include "ctr_defs.vh"
module tb_ctr_timer;
    reg         mclk_in = 1'h0;
    reg         rst_n_in = 1'h0;
    reg  [3:0]  addr_in = 4'h0;
    reg  [15:0] wdata_in = 16'h0000;
    reg         wr_in = 1'h0;
    reg         rd_in = 1'h0;
    reg         gate_in = 1'h0;
    reg         go = 1'h0;
    reg  [7:0]  n_edges = 8'h00;
    reg         pulse_q = 1'h0;
    wire [15:0] rdata_out;
    wire        ext_clk, busy, pulse_out;
    integer     miscompares = 0;
    integer     n_tests = 0;
    integer     acts = 0;
    integer     i;
    always #25 mclk_in = ~mclk_in;
    ctr_timer #(.WIN_UNIT_CYC(20)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .ext_clk_in(ext_clk), .gate_in(gate_in), .pulse_out(pulse_out));
    ext_wiring far (.mclk_in(mclk_in), .go_in(go), .edges_in(n_edges),
        .ext_clk_out(ext_clk), .busy_out(busy));
    // tally of pulses going active; every run uses active-high polarity
    always @(posedge mclk_in) begin
        pulse_q <= pulse_out;
        if (pulse_out === 1'h1 && pulse_q === 1'h0) acts = acts + 1;
    end
    task check(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge mclk_in);
            addr_in  <= a;
            wdata_in <= d;
            wr_in    <= 1'h1;
            @(posedge mclk_in);
            wr_in <= 1'h0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rdc(input string nm, input [3:0] a, input [15:0] m, input [15:0] e);
        begin
            @(posedge mclk_in);
            addr_in <= a;
            rd_in   <= 1'h1;
            @(posedge mclk_in);
            rd_in <= 1'h0;
            #1;
            check(nm, rdata_out & m, e);
        end
    endtask
    task start(input [15:0] c);
        begin
            wr(`ADDR_CTRL, c);
            wr(`ADDR_CTRL, c | 16'h0001);
            acts = 0;
        end
    endtask
    task burst(input [7:0] n);
        integer k;
        begin
            @(posedge mclk_in);
            n_edges <= n;
            go      <= 1'h1;
            @(posedge mclk_in);
            go <= 1'h0;
            for (k = 0; k < 4000 && (k < 2 || busy); k = k + 1) @(posedge mclk_in);
            repeat (6) @(posedge mclk_in);
            #1;
        end
    endtask
    task set_gate(input v);
        begin
            @(posedge mclk_in);
            gate_in <= v;
            repeat (6) @(posedge mclk_in);
            #1;
        end
    endtask
    function [15:0] ctl(input [2:0] m, input s, input [2:0] g);
        ctl = {7'h00, 1'h1, g, s, m, 1'h0};
    endfunction
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // watchdog far beyond the expected run of under two thousand cycles
    initial begin
        #2000000;
        miscompares = miscompares + 1;
        close_out;
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'h1;
        repeat (4) @(posedge mclk_in);
        rdc("ctrl", `ADDR_CTRL, 16'hFFFF, 16'h0000);
        rdc("div", `ADDR_DIVIDER, 16'hFFFF, `RST_DIVIDER);
        rdc("act", `ADDR_ACTIVE, 16'hFFFF, `RST_ACTIVE);
        rdc("win", `ADDR_WINDOW, 16'hFFFF, `RST_WINDOW);
        rdc("unmapped", 4'hF, 16'hFFFF, 16'h0000);
        check("idle", {15'h0000, pulse_out}, 16'h0001);
        wr(`ADDR_COUNT, 16'h1234);
        rdc("count ro", `ADDR_COUNT, 16'hFFFF, 16'h0000);
        // windowed: edges after the 5-unit window closes are not counted
        wr(`ADDR_WINDOW, 16'h0005);
        start(ctl(`MODE_FREQ_WIN, 1'h1, `GATE_NONE));
        burst(8'h08);
        repeat (60) @(posedge mclk_in);
        burst(8'h04);
        rdc("win count", `ADDR_COUNT, 16'hFFFF, 16'h0008);
        rdc("win done", `ADDR_STATUS, 16'h0004, 16'h0004);
        // gated count: only edges inside the high gate; gate type matches the pulse
        start(ctl(`MODE_COUNT, 1'h1, `GATE_HIGH));
        burst(8'h05);
        set_gate(1'h1);
        burst(8'h06);
        set_gate(1'h0);
        burst(8'h03);
        rdc("gated count", `ADDR_COUNT, 16'hFFFF, 16'h0006);
        // low level gate: edges count only while the gate pin is low
        start(ctl(`MODE_COUNT, 1'h1, `GATE_LOW));
        burst(8'h03);
        set_gate(1'h1);
        rdc("gate sync", `ADDR_STATUS, 16'h0008, 16'h0008);
        burst(8'h02);
        set_gate(1'h0);
        rdc("low gate count", `ADDR_COUNT, 16'hFFFF, 16'h0003);
        // rate from external clock, divider 4, then gate low
        wr(`ADDR_DIVIDER, 16'h0004);
        wr(`ADDR_ACTIVE, 16'h0001);
        start(ctl(`MODE_RATE, 1'h1, `GATE_HIGH));
        set_gate(1'h1);
        burst(8'h08);
        check("rate pulses", acts[15:0], 16'h0002);
        set_gate(1'h0);
        burst(8'h08);
        check("gate off", acts[15:0], 16'h0002);
        // internal source: 1 MHz from 12 ticks, about 20 pulses in 400 cycles
        set_gate(1'h1);
        wr(`ADDR_DIVIDER, 16'h000C);
        start(ctl(`MODE_RATE, 1'h0, `GATE_HIGH));
        repeat (400) @(posedge mclk_in);
        #1;
        check("internal rate", {15'h0000, acts >= 19 && acts <= 21}, 16'h0001);
        wr(`ADDR_CTRL, ctl(`MODE_RATE, 1'h0, `GATE_HIGH));
        // let a pulse launched on the disabling edge settle before the tally restarts
        repeat (3) @(posedge mclk_in);
        #1;
        acts = 0;
        repeat (100) @(posedge mclk_in);
        #1;
        check("sw stop", acts[15:0], 16'h0000);
        // one-shot: inactive part first, one pulse, later triggers ignored
        set_gate(1'h0);
        wr(`ADDR_DIVIDER, 16'h0004);
        wr(`ADDR_ACTIVE, 16'h0002);
        start(ctl(`MODE_ONESHOT, 1'h1, `GATE_RISE));
        set_gate(1'h1);
        check("delay first", {15'h0000, pulse_out}, 16'h0000);
        burst(8'h08);
        check("one pulse", acts[15:0], 16'h0001);
        set_gate(1'h0);
        set_gate(1'h1);
        burst(8'h08);
        check("stays done", acts[15:0], 16'h0001);
        rdc("done state", `ADDR_STATUS, 16'h0003, 16'h0002);
        // repetitive: a pulse per trigger, mid-pulse trigger not queued
        set_gate(1'h0);
        start(ctl(`MODE_REPEAT, 1'h1, `GATE_RISE));
        for (i = 0; i < 2; i = i + 1) begin
            set_gate(1'h1);
            burst(8'h04);
            set_gate(1'h0);
        end
        check("repeat", acts[15:0], 16'h0002);
        set_gate(1'h1);
        burst(8'h02);
        set_gate(1'h0);
        set_gate(1'h1);
        burst(8'h02);
        burst(8'h04);
        check("no queue", acts[15:0], 16'h0003);
        close_out;
    end
endmodule
